/* rtl/tpc_port.v */
`include "tpc_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tpc_port #(
    parameter DEPTH = `TPC_FIFO_DEPTH,
    parameter AW = 3
) (
    input wire sys_clk,
    input wire reset_n,
    input wire [31:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_ff,
    output wire tx_char_valid,
    input wire tx_char_ready,
    output wire [8:0] tx_char_data,
    input wire rx_char_valid,
    output wire rx_char_ready,
    input wire [8:0] rx_char_data,
    input wire seq_tx_done,
    input wire seq_rx_done,
    input wire rx_error,
    input wire rx_header_ok,
    input wire timecode_in,
    input wire timecode_received_flag,
    output reg bus_irq_ff,
    output reg gen_irq_req_ff,
    output reg [7:0] gen_irq_port_ff,
    output reg tx_halt_ff,
    output reg rx_halt_ff,
    output wire tx_state_clear,
    output wire rx_state_clear,
    output wire port_enable
);
    ////////////////////////////////////////////////////////////////
    // control registers
    reg [7:0] general_irq_port_number_ff;
    reg state_retain_ff;
    reg general_irq_generate_ff;
    reg timecode_irq_enable_ff;
    reg sequence_irq_enable_ff;
    reg err_mask_ff;
    reg stop_on_err_ff;
    reg enable_ff;
    reg tx_sequence_run_ff;
    reg rx_sequence_run_ff;
    reg auto_repeat_ff;
    reg soft_rst_ff;
    reg header_seen_ff;
    reg err_seen_ff;
    // sync of pin-level inputs
    reg [1:0] err_sync_ff;
    reg [1:0] hdr_sync_ff;
    reg [1:0] tc_sync_ff;
    reg [1:0] txd_sync_ff;
    reg [1:0] rxd_sync_ff;
    reg [1:0] tcf_sync_ff;
    reg tc_prev_ff;
    reg txd_prev_ff;
    reg rxd_prev_ff;

    function hit_win;
        input [31:0] a;
        input [31:0] base;
        begin
            hit_win = ((a & `TPC_WIN_MASK) == base);
        end
    endfunction

    wire protection_key_wr;
    wire run_wr;
    wire din_rd;
    wire dout_wr;
    wire tx_in_ready;
    wire rx_out_valid;
    wire [8:0] rx_out_data;
    wire [AW:0] tx_level;
    wire [AW:0] rx_level;
    wire rx_pop;
    wire tx_push;
    wire err_ev;
    wire tc_ev;
    wire txd_ev;
    wire rxd_ev;
    wire flush;
    wire key_ok;

    // fifo handshake before the enable gate
    wire tx_out_valid;
    wire rx_in_ready;

    assign key_ok = (reg_wdata[`TPC_KEY_MSB:`TPC_KEY_LSB] == `TPC_KEY); // R1
    assign protection_key_wr = reg_wr && (reg_addr == `TPC_PROTECTION_KEY_ADDR) && key_ok; // R1
    assign run_wr = reg_wr && (reg_addr == `TPC_RUN_ADDR);
    assign din_rd = reg_rd && hit_win(reg_addr, `TPC_DIN_BASE); // R13
    assign dout_wr = reg_wr && hit_win(reg_addr, `TPC_DOUT_BASE); // R15
    assign port_enable = enable_ff;
    assign flush = soft_rst_ff;
    assign rx_pop = din_rd && rx_out_valid && enable_ff && !rx_sequence_run_ff; // R12 R10
    assign tx_push = dout_wr && tx_in_ready && enable_ff && !tx_sequence_run_ff; // R14 R10

    // no handshake toward the router while off: nothing lost or sent twice
    assign tx_char_valid = tx_out_valid && enable_ff; // R10
    assign rx_char_ready = rx_in_ready && enable_ff; // R10


    ////////////////////////////////////////////////////////////////
    // character fifos
    tpc_fifo #(.WIDTH(`TPC_CHAR_W), .DEPTH(DEPTH), .AW(AW)) u_tx_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .flush(flush),
        .in_valid(tx_push),
        .in_ready(tx_in_ready),
        .in_data(reg_wdata[8:0]),
        .out_valid(tx_out_valid),
        .out_ready(tx_char_ready && enable_ff),
        .out_data(tx_char_data),
        .level(tx_level)
    );
    tpc_fifo #(.WIDTH(`TPC_CHAR_W), .DEPTH(DEPTH), .AW(AW)) u_rx_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .flush(flush),
        .in_valid(rx_char_valid && enable_ff),
        .in_ready(rx_in_ready),
        .in_data(rx_char_data),
        .out_valid(rx_out_valid),
        .out_ready(rx_pop),
        .out_data(rx_out_data),
        .level(rx_level)
    );

    ////////////////////////////////////////////////////////////////
    // event synchronisers
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            err_sync_ff <= 2'h0;
            hdr_sync_ff <= 2'h0;
            tc_sync_ff <= 2'h0;
            txd_sync_ff <= 2'h0;
            rxd_sync_ff <= 2'h0;
            tcf_sync_ff <= 2'h0;
            tc_prev_ff <= 1'b0;
            txd_prev_ff <= 1'b0;
            rxd_prev_ff <= 1'b0;
        end else begin
            err_sync_ff <= {err_sync_ff[0], rx_error};
            hdr_sync_ff <= {hdr_sync_ff[0], rx_header_ok};
            tc_sync_ff <= {tc_sync_ff[0], timecode_in};
            txd_sync_ff <= {txd_sync_ff[0], seq_tx_done};
            rxd_sync_ff <= {rxd_sync_ff[0], seq_rx_done};
            tcf_sync_ff <= {tcf_sync_ff[0], timecode_received_flag};
            tc_prev_ff <= tc_sync_ff[1];
            txd_prev_ff <= txd_sync_ff[1];
            rxd_prev_ff <= rxd_sync_ff[1];
        end
    end
    assign tc_ev = tc_sync_ff[1] && !tc_prev_ff;
    assign txd_ev = txd_sync_ff[1] && !txd_prev_ff;
    assign rxd_ev = rxd_sync_ff[1] && !rxd_prev_ff;
    // errors count only after a good header while masked
    assign err_ev = err_sync_ff[1] && (!err_mask_ff || header_seen_ff) && enable_ff; // R8
    wire first_err;
    assign first_err = err_ev && stop_on_err_ff && !err_seen_ff; // R9

    ////////////////////////////////////////////////////////////////
    // control register writes
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            general_irq_port_number_ff <= `TPC_GPORT_RST;
            state_retain_ff <= 1'b0;
            general_irq_generate_ff <= 1'b0;
            timecode_irq_enable_ff <= 1'b0;
            sequence_irq_enable_ff <= 1'b0;
            err_mask_ff <= 1'b0;
            stop_on_err_ff <= 1'b0;
            enable_ff <= 1'b0;
            soft_rst_ff <= 1'b0;
        end else begin
            // one-cycle strobe, never reads back
            soft_rst_ff <= protection_key_wr && reg_wdata[`TPC_BIT_RST]; // R4
            if (soft_rst_ff) begin
                general_irq_port_number_ff <= `TPC_GPORT_RST; // R4
                state_retain_ff <= 1'b0;
                general_irq_generate_ff <= 1'b0;
                timecode_irq_enable_ff <= 1'b0;
                sequence_irq_enable_ff <= 1'b0;
                err_mask_ff <= 1'b0;
                stop_on_err_ff <= 1'b0;
                enable_ff <= 1'b0;
            end else if (protection_key_wr) begin
                general_irq_port_number_ff <= reg_wdata[`TPC_GPORT_MSB:`TPC_GPORT_LSB]; // R2
                state_retain_ff <= reg_wdata[`TPC_BIT_RETAIN];
                general_irq_generate_ff <= reg_wdata[`TPC_BIT_GENERAL_IRQ_GENERATE];
                timecode_irq_enable_ff <= reg_wdata[`TPC_BIT_TIMECODE_IRQ_ENABLE];
                sequence_irq_enable_ff <= reg_wdata[`TPC_BIT_IE];
                err_mask_ff <= reg_wdata[`TPC_BIT_MASK];
                stop_on_err_ff <= reg_wdata[`TPC_BIT_STOP];
                enable_ff <= reg_wdata[`TPC_BIT_EN]; // R10
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // sequence run bits, error stop, state clear
    reg tx_clr_ff;
    reg rx_clr_ff;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_sequence_run_ff <= 1'b0;
            rx_sequence_run_ff <= 1'b0;
            auto_repeat_ff <= 1'b0;
            header_seen_ff <= 1'b0;
            err_seen_ff <= 1'b0;
            tx_halt_ff <= 1'b0;
            rx_halt_ff <= 1'b0;
            tx_clr_ff <= 1'b0;
            rx_clr_ff <= 1'b0;
        end else if (soft_rst_ff) begin
            tx_sequence_run_ff <= 1'b0;
            rx_sequence_run_ff <= 1'b0;
            auto_repeat_ff <= 1'b0;
            header_seen_ff <= 1'b0;
            err_seen_ff <= 1'b0;
            tx_halt_ff <= 1'b0;
            rx_halt_ff <= 1'b0;
            tx_clr_ff <= 1'b1;
            rx_clr_ff <= 1'b1;
        end else begin
            tx_clr_ff <= 1'b0;
            rx_clr_ff <= 1'b0;
            if (hdr_sync_ff[1]) begin
                header_seen_ff <= 1'b1; // R8
            end
            if (first_err) begin
                err_seen_ff <= 1'b1; // R9
                tx_halt_ff <= 1'b1; // R9
                rx_halt_ff <= 1'b1; // R9
                tx_sequence_run_ff <= 1'b0; // R9
                rx_sequence_run_ff <= 1'b0; // R9
                // retain bit keeps side state through the error stop
                tx_clr_ff <= !state_retain_ff; // R3
                rx_clr_ff <= !state_retain_ff; // R3
            end else if (run_wr) begin
                tx_sequence_run_ff <= reg_wdata[`TPC_BIT_TXRUN];
                rx_sequence_run_ff <= reg_wdata[`TPC_BIT_RXRUN];
                auto_repeat_ff <= reg_wdata[`TPC_BIT_AR];
                tx_clr_ff <= tx_sequence_run_ff && !reg_wdata[`TPC_BIT_TXRUN] && !state_retain_ff; // R3
                rx_clr_ff <= rx_sequence_run_ff && !reg_wdata[`TPC_BIT_RXRUN] && !state_retain_ff; // R3
                if (reg_wdata[`TPC_BIT_TXRUN] || reg_wdata[`TPC_BIT_RXRUN]) begin
                    err_seen_ff <= 1'b0;
                    // a header in this very cycle still counts
                    header_seen_ff <= hdr_sync_ff[1]; // R8
                    tx_halt_ff <= 1'b0;
                    rx_halt_ff <= 1'b0;
                end
            end else begin
                if (txd_ev && !auto_repeat_ff) begin
                    tx_sequence_run_ff <= 1'b0;
                end
                if (rxd_ev) begin
                    rx_sequence_run_ff <= 1'b0;
                end
            end
        end
    end
    assign tx_state_clear = tx_clr_ff;
    assign rx_state_clear = rx_clr_ff;

    ////////////////////////////////////////////////////////////////
    // interrupts toward bus and router
    wire seq_irq_ev;
    wire tc_irq_ev;
    wire gen_irq_ev;
    assign seq_irq_ev = sequence_irq_enable_ff && (txd_ev || rxd_ev || first_err); // R7
    assign tc_irq_ev = timecode_irq_enable_ff && tc_ev && !tcf_sync_ff[1]; // R6
    // router interrupt only on a non-repeating transmit end or the first error
    assign gen_irq_ev = general_irq_generate_ff && ((txd_ev && !auto_repeat_ff) || first_err); // R5

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_irq_ff <= 1'b0;
            gen_irq_req_ff <= 1'b0;
            gen_irq_port_ff <= 8'h00;
        end else begin
            bus_irq_ff <= seq_irq_ev || tc_irq_ev; // R6 R7
            gen_irq_req_ff <= gen_irq_ev; // R5
            gen_irq_port_ff <= general_irq_port_number_ff; // R5
        end
    end

    ////////////////////////////////////////////////////////////////
    // read path
    wire rx_ae;
    assign rx_ae = (rx_level <= `TPC_AE_LEVEL);
    wire tx_af;
    assign tx_af = (tx_level >= DEPTH - 1);
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_ff <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata_ff <= 32'h0000_0000; // R16
            if (reg_addr == `TPC_PROTECTION_KEY_ADDR) begin
                reg_rdata_ff[`TPC_GPORT_MSB:`TPC_GPORT_LSB] <= general_irq_port_number_ff;
                reg_rdata_ff[`TPC_BIT_RETAIN] <= state_retain_ff;
                reg_rdata_ff[`TPC_BIT_GENERAL_IRQ_GENERATE] <= general_irq_generate_ff;
                reg_rdata_ff[`TPC_BIT_TIMECODE_IRQ_ENABLE] <= timecode_irq_enable_ff;
                reg_rdata_ff[`TPC_BIT_IE] <= sequence_irq_enable_ff;
                reg_rdata_ff[`TPC_BIT_MASK] <= err_mask_ff;
                reg_rdata_ff[`TPC_BIT_STOP] <= stop_on_err_ff;
                reg_rdata_ff[`TPC_BIT_EN] <= enable_ff;
            end else if (reg_addr == `TPC_RUN_ADDR) begin
                reg_rdata_ff[`TPC_BIT_TXRUN] <= tx_sequence_run_ff;
                reg_rdata_ff[`TPC_BIT_RXRUN] <= rx_sequence_run_ff;
                reg_rdata_ff[`TPC_BIT_AR] <= auto_repeat_ff;
            end else if (reg_addr == `TPC_STAT_ADDR) begin
                // status word: fifo full, almost-full, available and almost-empty flags and sticky error
                reg_rdata_ff[`TPC_ST_TXF] <= !tx_in_ready;
                reg_rdata_ff[`TPC_ST_TX_FIFO_ALMOST_FULL] <= tx_af;
                reg_rdata_ff[`TPC_ST_RX_CHAR_AVAILABLE] <= rx_out_valid;
                reg_rdata_ff[`TPC_ST_RX_ALMOST_EMPTY] <= rx_ae;
                reg_rdata_ff[`TPC_ST_ERR] <= err_seen_ff;
            end else if (din_rd) begin
                reg_rdata_ff[`TPC_BIT_RX_ALMOST_EMPTY] <= rx_ae; // R11
                reg_rdata_ff[`TPC_BIT_RX_CHAR_AVAILABLE] <= rx_out_valid; // R11
                if (rx_pop) begin
                    reg_rdata_ff[8:0] <= rx_out_data; // R12
                end
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/tpc_regs.vh */
// Function
// R1: write accepted only with key 0x55AA
// R2: hold 8-bit general interrupt port number
// R3: state_retain keeps side state when stopped
// R4: reset bit resets port, write-only
// R5: general interrupt access on sequence end/error (code: non-repeating transmit end or first error only, not receive end)
// R6: timecode interrupt unless received flag set
// R7: sequence interrupt at end and first error
// R8: error mask until correct header received
// R9: stop-on-error halts and ends both sequences
// R10: transfers need port enable
// R11: read flags sampled before pop
// R12: read pops only when available, enabled, stopped
// R13: input window at eight word addresses
// R14: write pushes only when room, enabled, stopped
// R15: output window at eight word addresses
// R16: output window reads as zero
`ifndef TPC_REGS_VH
`define TPC_REGS_VH
`define TPC_ADDR_W 32
`define TPC_PROTECTION_KEY_ADDR 32'hffe0_025c
`define TPC_RUN_ADDR 32'hffe0_0260
`define TPC_STAT_ADDR 32'hffe0_0264
`define TPC_DIN_BASE 32'hffe0_0280
`define TPC_DOUT_BASE 32'hffe0_02a0
`define TPC_WIN_MASK 32'hffff_ffe3
`define TPC_KEY 16'h55aa
`define TPC_KEY_MSB 31
`define TPC_KEY_LSB 16
`define TPC_GPORT_MSB 15
`define TPC_GPORT_LSB 8
`define TPC_GPORT_RST 8'h1f
`define TPC_BIT_RETAIN 7
`define TPC_BIT_RST 6
`define TPC_BIT_GENERAL_IRQ_GENERATE 5
`define TPC_BIT_TIMECODE_IRQ_ENABLE 4
`define TPC_BIT_IE 3
`define TPC_BIT_MASK 2
`define TPC_BIT_STOP 1
`define TPC_BIT_EN 0
`define TPC_BIT_TXRUN 0
`define TPC_BIT_RXRUN 1
`define TPC_BIT_AR 2
`define TPC_ST_TXF 0
`define TPC_ST_TX_FIFO_ALMOST_FULL 1
`define TPC_ST_RX_CHAR_AVAILABLE 2
`define TPC_ST_RX_ALMOST_EMPTY 3
`define TPC_ST_ERR 4
`define TPC_BIT_RX_ALMOST_EMPTY 10
`define TPC_BIT_RX_CHAR_AVAILABLE 9
`define TPC_CHAR_W 9
`define TPC_FIFO_DEPTH 8
`define TPC_AE_LEVEL 1
`endif

/* rtl/tpc_mem.v */
`timescale 1ns/1ps
`default_nettype none
module tpc_mem #(
    parameter WIDTH = 9,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire sys_clk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data_ff
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_ff <= mem[rd_addr];
    end
endmodule
`default_nettype wire

/* rtl/tpc_fifo.v */
`timescale 1ns/1ps
`default_nettype none
module tpc_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire sys_clk,
    input wire reset_n,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0] level
);
    reg [AW:0] wp_ff;
    reg [AW:0] rp_ff;
    wire push;
    wire pop;
    wire [AW:0] nxt_rp;
    wire [WIDTH-1:0] mem_q;
    assign level = wp_ff - rp_ff;
    assign in_ready = (level != DEPTH[AW:0]);
    assign out_valid = (level != {(AW+1){1'b0}});
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
    // read data registered from lookahead pointer
    tpc_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .sys_clk(sys_clk),
        .wr_en(push),
        .wr_addr(wp_ff[AW-1:0]),
        .wr_data(in_data),
        .rd_addr(nxt_rp[AW-1:0]),
        .rd_data_ff(mem_q)
    );
    reg byp_ff;
    reg [WIDTH-1:0] byp_data_ff;
    // a push into the slot being fetched bypasses the stale memory word
    assign out_data = byp_ff ? byp_data_ff : mem_q;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wp_ff <= {(AW+1){1'b0}};
            rp_ff <= {(AW+1){1'b0}};
            byp_ff <= 1'b0;
            byp_data_ff <= {WIDTH{1'b0}};
        end else if (flush) begin
            wp_ff <= {(AW+1){1'b0}};
            rp_ff <= {(AW+1){1'b0}};
            byp_ff <= 1'b0;
        end else begin
            byp_ff <= push && (wp_ff[AW-1:0] == nxt_rp[AW-1:0]);
            if (push) begin
                wp_ff <= wp_ff + 1'b1;
                byp_data_ff <= in_data;
            end
            rp_ff <= nxt_rp;
        end
    end
endmodule
`default_nettype wire

/* verif/tpc_port_sva.sv */
`include "tpc_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tpc_port_sva (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_ff,
    input wire logic tx_char_valid,
    input wire logic bus_irq_ff,
    input wire logic gen_irq_req_ff,
    input wire logic tx_halt_ff,
    input wire logic rx_halt_ff,
    input wire logic tx_state_clear,
    input wire logic rx_state_clear,
    input wire logic port_enable
);
    logic protection_key_hit, din_hit, dout_hit, key_ok, rst_wr;
    assign protection_key_hit = reg_addr == `TPC_PROTECTION_KEY_ADDR;
    assign din_hit = (reg_addr & `TPC_WIN_MASK) == `TPC_DIN_BASE;
    assign dout_hit = (reg_addr & `TPC_WIN_MASK) == `TPC_DOUT_BASE;
    assign key_ok = reg_wdata[31:16] == `TPC_KEY;
    assign rst_wr = reg_wr && protection_key_hit && key_ok && reg_wdata[`TPC_BIT_RST];
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    dout_zero_a: assert property (reg_rd && dout_hit |=> reg_rdata_ff == 32'h0000_0000)
        else $error("output window read not zero");
    key_hidden_a: assert property (reg_rd && protection_key_hit |=> reg_rdata_ff[31:16] == 16'h0000 &&
        !reg_rdata_ff[`TPC_BIT_RST]) else $error("key or reset bit readable");
    bad_key_a: assert property (reg_wr && protection_key_hit && !key_ok && !$past(reg_wr)
        |=> $stable(port_enable)) else $error("unkeyed write took effect");
    soft_reset_a: assert property (rst_wr |-> ##[1:3] (tx_state_clear && rx_state_clear))
        else $error("soft reset did not clear state");
    off_no_push_a: assert property (reg_wr && dout_hit && !port_enable && !tx_char_valid
        |=> (!tx_char_valid) [*2]) else $error("push while disabled");
    off_no_pop_a: assert property (reg_rd && din_hit && !port_enable
        |=> reg_rdata_ff[8:0] == 9'h000) else $error("char returned while disabled");
    irq_pulse_a: assert property (bus_irq_ff |=> !bus_irq_ff)
        else $error("bus interrupt longer than one cycle");
    gen_pulse_a: assert property ($rose(gen_irq_req_ff) |=> !gen_irq_req_ff)
        else $error("general interrupt request longer than one cycle");
    halt_pair_a: assert property ($rose(tx_halt_ff) |-> rx_halt_ff)
        else $error("transmitter halted alone");
    soft_reset_c: cover property (rst_wr);
    irq_c: cover property (bus_irq_ff);
    gen_c: cover property (gen_irq_req_ff);
    halt_c: cover property ($rose(rx_halt_ff));
endmodule
bind tpc_port tpc_port_sva chk_u (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .tx_char_valid(tx_char_valid), .bus_irq_ff(bus_irq_ff), .gen_irq_req_ff(gen_irq_req_ff),
    .tx_halt_ff(tx_halt_ff), .rx_halt_ff(rx_halt_ff), .tx_state_clear(tx_state_clear),
    .rx_state_clear(rx_state_clear), .port_enable(port_enable));
`default_nettype wire

/* verif/tpc_router_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tpc_router_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic stall,
    input wire logic tx_char_valid,
    output logic tx_char_ready,
    input wire logic [8:0] tx_char_data,
    output logic rx_char_valid,
    input wire logic rx_char_ready,
    output logic [8:0] rx_char_data
);
    logic [8:0] send_q[$];
    logic [8:0] got_q[$];
    ////////////////////////////////////////
    // takes characters unless stalled, offers queued ones held until taken
    assign tx_char_ready = !stall;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_char_valid <= 1'b0;
            rx_char_data <= 9'h155;
        end else begin
            if (tx_char_valid && tx_char_ready) begin
                got_q.push_back(tx_char_data);
            end
            if (!rx_char_valid || rx_char_ready) begin
                if (send_q.size() > 0) begin
                    rx_char_valid <= 1'b1;
                    rx_char_data <= send_q.pop_front();
                end else begin
                    rx_char_valid <= 1'b0;
                    rx_char_data <= ~rx_char_data;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* verif/tpc_port_tb.sv */
`include "tpc_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tpc_port_tb;
    logic sys_clk, reset_n, reg_wr, reg_rd, stall, txv, txr, rxv, rxr;
    logic irq, gen, txh, rxh, txc, rxc, pen;
    logic [31:0] reg_addr, reg_wdata, rdata, d;
    logic [8:0] txd, rxd;
    logic [7:0] gport, gp_seen;
    logic [5:0] ev;
    int err_count, compares, n_irq, n_gen, n_halt, n_clr, i;
    tpc_port dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
        .tx_char_valid(txv), .tx_char_ready(txr), .tx_char_data(txd), .rx_char_valid(rxv),
        .rx_char_ready(rxr), .rx_char_data(rxd), .seq_tx_done(ev[0]), .seq_rx_done(ev[1]),
        .rx_error(ev[2]), .rx_header_ok(ev[3]), .timecode_in(ev[4]),
        .timecode_received_flag(ev[5]), .bus_irq_ff(irq), .gen_irq_req_ff(gen),
        .gen_irq_port_ff(gport), .tx_halt_ff(txh), .rx_halt_ff(rxh), .tx_state_clear(txc),
        .rx_state_clear(rxc), .port_enable(pen));
    tpc_router_model model_u (.sys_clk(sys_clk), .reset_n(reset_n), .stall(stall),
        .tx_char_valid(txv), .tx_char_ready(txr), .tx_char_data(txd), .rx_char_valid(rxv),
        .rx_char_ready(rxr), .rx_char_data(rxd));
    ////////////////////////////////////////
    task report_and_stop;
        if (err_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
            err_count++;
        end
    endtask
    task wr(input logic [31:0] a, input logic [31:0] v);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task rd(input logic [31:0] a);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = rdata;
        @(posedge sys_clk);
    endtask
    task rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
        rd(a);
        chk(nm, e, d);
    endtask
    // raise one event input and count what comes out
    task evr(input int k, input int ei, input int eg, input int eh);
        n_irq = 0;
        n_gen = 0;
        n_halt = 0;
        ev[k] <= 1'b1;
        repeat (12) begin
            @(posedge sys_clk);
            #1;
            if (irq === 1'b1) n_irq++;
            if (gen === 1'b1) begin
                n_gen++;
                gp_seen = gport;
            end
            if (txh === 1'b1 && rxh === 1'b1) n_halt = 1;
        end
        @(posedge sys_clk);
        ev[k] <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk("irq", ei, n_irq);
        chk("gen", eg, n_gen);
        chk("halt", eh, n_halt);
    endtask
    // state-clear pulses, counted in the cycle they stand
    always @(posedge sys_clk) begin
        if (txc === 1'b1) n_clr++;
        if (rxc === 1'b1) n_clr++;
    end
    ////////////////////////////////////////
    task t_reset;
        rdc("protection_key", `TPC_PROTECTION_KEY_ADDR, 32'h0000_1f00);
        rdc("din", `TPC_DIN_BASE, 32'h0000_0400);
        rdc("dout", `TPC_DOUT_BASE + 32'h14, 32'h0000_0000);
        wr(`TPC_DOUT_BASE, 32'h0000_0155);
        chk("txv", 32'h0, {31'h0, txv});
    endtask
    task t_key;
        wr(`TPC_PROTECTION_KEY_ADDR, 32'h1234_4201);
        rdc("badkey", `TPC_PROTECTION_KEY_ADDR, 32'h0000_1f00);
        wr(`TPC_PROTECTION_KEY_ADDR, 32'h55aa_4201);
        rdc("protection_key", `TPC_PROTECTION_KEY_ADDR, 32'h0000_4201);
        chk("en", 32'h1, {31'h0, pen});
    endtask
    task t_tx;
        stall <= 1'b1;
        for (i = 0; i < 10; i++) begin
            wr(`TPC_DOUT_BASE + 32'(4 * (i % 8)), {23'h0, i[0], 8'hc0 + i[7:0]});
        end
        rd(`TPC_STAT_ADDR);
        chk("stat", 32'h0000_000b, d & 32'h0000_001f);
        stall <= 1'b0;
        for (i = 0; i < 40 && model_u.got_q.size() < 8; i++) @(posedge sys_clk);
        repeat (6) @(posedge sys_clk);
        chk("count", 32'h8, model_u.got_q.size());
        for (i = 0; i < 8; i++) begin
            chk("char", {23'h0, i[0], 8'hc0 + i[7:0]}, {23'h0, model_u.got_q[i]});
        end
        chk("txv", 32'h0, {31'h0, txv});
    endtask
    task t_rx;
        model_u.send_q.push_back(9'h1a5);
        model_u.send_q.push_back(9'h03c);
        model_u.send_q.push_back(9'h17e);
        for (i = 0; i < 40 && (model_u.send_q.size() > 0 || rxv === 1'b1); i++) begin
            @(posedge sys_clk);
        end
        rdc("din0", `TPC_DIN_BASE + 32'h1c, 32'h0000_03a5);
        rdc("din1", `TPC_DIN_BASE + 32'h04, 32'h0000_023c);
        rdc("din2", `TPC_DIN_BASE + 32'h08, 32'h0000_077e);
        rdc("din3", `TPC_DIN_BASE + 32'h10, 32'h0000_0400);
    endtask
    task t_soft;
        wr(`TPC_PROTECTION_KEY_ADDR, 32'h55aa_4241);
        rdc("protection_key", `TPC_PROTECTION_KEY_ADDR, 32'h0000_1f00);
        chk("en", 32'h0, {31'h0, pen});
    endtask
    task t_evt;
        wr(`TPC_PROTECTION_KEY_ADDR, 32'h55aa_4229);
        evr(0, 1, 1, 0);
        chk("gport", 32'h42, {24'h0, gp_seen});
        evr(1, 1, 0, 0);
        wr(`TPC_PROTECTION_KEY_ADDR, 32'h55aa_1f11);
        evr(4, 1, 0, 0);
        ev[5] <= 1'b1;
        evr(4, 0, 0, 0);
        ev[5] <= 1'b0;
        wr(`TPC_PROTECTION_KEY_ADDR, 32'h55aa_1f0f);
        evr(2, 0, 0, 0);
        ev[3] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        evr(2, 1, 0, 1);
    endtask
    task t_run;
        wr(`TPC_RUN_ADDR, 32'h0000_0003);
        rdc("run", `TPC_RUN_ADDR, 32'h0000_0003);
        n_clr = 0;
        wr(`TPC_RUN_ADDR, 32'h0000_0000);
        @(posedge sys_clk);
        chk("clr", 32'h2, n_clr);
        wr(`TPC_PROTECTION_KEY_ADDR, 32'h55aa_1faf);
        wr(`TPC_RUN_ADDR, 32'h0000_0003);
        n_clr = 0;
        wr(`TPC_RUN_ADDR, 32'h0000_0000);
        wr(`TPC_RUN_ADDR, 32'h0000_0003);
        evr(2, 1, 1, 1);
        chk("clr", 32'h0, n_clr);
        rdc("run", `TPC_RUN_ADDR, 32'h0000_0000);
    endtask
    ////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        report_and_stop;
    end
    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 32'h0000_0000;
        reg_wdata = 32'h0000_0000;
        stall = 1'b0;
        ev = 6'h00;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        t_reset;
        t_key;
        t_tx;
        t_rx;
        t_soft;
        t_evt;
        t_run;
        report_and_stop;
    end
endmodule
`default_nettype wire
